// ===== haptic_loop_pkg.sv
// Purpose: Shared constants for the haptic loop control front end.
// Assumes: Registers sit one per 32-bit word, byte address = 4 * index.
// Notes: Reset values are neutral starting points, not tuned for any actuator.
package haptic_loop_pkg;
    // Register indices
    localparam logic [5:0] IDX_STATUS = 6'h00;
    localparam logic [5:0] IDX_MODE = 6'h01;
    localparam logic [5:0] IDX_LIBRARY = 6'h03;
    localparam logic [5:0] IDX_GO = 6'h0C;
    localparam logic [5:0] IDX_RATED = 6'h16;
    localparam logic [5:0] IDX_OD_LIMIT = 6'h17;
    localparam logic [5:0] IDX_COMP = 6'h18;
    localparam logic [5:0] IDX_BEMF_NORM = 6'h19;
    localparam logic [5:0] IDX_FEEDBACK = 6'h1A;
    localparam logic [5:0] IDX_CTRL1 = 6'h1B;
    localparam logic [5:0] IDX_CTRL2 = 6'h1C;
    localparam logic [5:0] IDX_CTRL3 = 6'h1D;
    localparam logic [5:0] IDX_PERIOD = 6'h22;
    // Field positions
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_FAULT = 3;
    localparam int MODE_STANDBY = 6;
    localparam int FB_ACT_LRA = 7;
    localparam int FB_BRAKE_LSB = 4;
    localparam int FB_LOOP_LSB = 2;
    localparam int FB_AMP_LSB = 0;
    localparam int CTRL1_BOOST = 7;
    localparam int CTRL2_STAB = 6;
    localparam int CTRL2_SAMPLE_LSB = 4;
    localparam int CTRL2_CALT_LSB = 2;
    localparam int CTRL3_ERM_OL = 5;
    localparam int CTRL3_DOUBLE = 2;
    localparam int CTRL3_LRA_OL = 0;
    // Reset values
    localparam logic [7:0] RST_MODE = 8'h40;
    localparam logic [2:0] RST_LIBRARY = 3'h1;
    localparam logic [7:0] RST_RATED = 8'h80;
    localparam logic [7:0] RST_OD_LIMIT = 8'hC0;
    localparam logic [7:0] RST_COMP = 8'h00;
    localparam logic [7:0] RST_BEMF_NORM = 8'h80;
    localparam logic [7:0] RST_FEEDBACK = 8'h24;
    localparam logic [7:0] RST_CTRL1 = 8'h80;
    localparam logic [7:0] RST_CTRL2 = 8'h10;
    localparam logic [7:0] RST_CTRL3 = 8'h00;
    // Interface modes and run sequencer
    typedef enum logic [2:0] {
        MODE_INTERNAL = 3'b000,
        MODE_PWM = 3'b011,
        MODE_DIAG = 3'b110,
        MODE_AUTOCAL = 3'b111
    } mode_t;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CAL = 2'b01,
        SEQ_DIAG = 2'b10
    } seq_t;
    // Timing
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned CAL_MS_0 = 150;
    localparam int unsigned CAL_MS_1 = 250;
    localparam int unsigned CAL_MS_2 = 500;
    localparam int unsigned CAL_MS_3 = 1000;
    localparam int unsigned DIAG_MS = 10;
    localparam logic [6:0] PWM_HALF_DIV = 7'd64;
    localparam logic [7:0] SAMPLE_HALF = 8'h80;
    localparam logic [2:0] BOOST_SAMPLES = 3'd4;
    // Loop and diagnostic thresholds
    localparam logic [7:0] DIAG_LEVEL = 8'h40;
    localparam logic [7:0] OPEN_LIMIT = 8'hF0;
    localparam logic [7:0] SHORT_LIMIT = 8'h04;
    localparam logic [7:0] CAL_MIN_BEMF = 8'h08;
    localparam logic [11:0] BRAKE_NEAR = 12'h010;
    localparam logic [4:0] BRAKE_MULT [0:7] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd6, 5'd8, 5'd16, 5'd0};
endpackage : haptic_loop_pkg

// ===== haptic_loop_control_frontend.sv
// Purpose: Feedback loop, calibration, diagnostics and PWM front end of a haptic driver.
// Assumes: backemf_level, backemf_positive and load_impedance come from hclk-domain sense logic.
// Notes: AHB-Lite slave; writes take no wait state, reads take one.
// Behaviour
// - Resonance period readable, updated only while tracking.
// - Startup boost doubles loop gain early.
// - Three-bit field sets brake to drive gain.
// - Stabilizer halves gain as braking ends.
// - Full scale gives rated level, clamp limits.
// - Failed calibration sets fault flag.
// - Calibration stores resistive-loss compensation factor.
// - Calibration stores back-EMF normalization factor.
// - Two-bit field selects calibration duration.
// - Two-bit field selects loop gain.
// - Amp gain field, written by calibration.
// - Longer sample time raises back-EMF gain.
// - Sample once per period, twice optionally.
// - Diagnostic flags open or shorted actuator.
// - Open-loop LRA commutates at PWM/128.
// - ERM open-loop amplitude follows duty, clamp scaled.
// - Three-bit mode field selects interface.
// - PWM mode drives continuously until standby.
// - LRA PWM tracks resonance unless open-loop.
// - Library select register picks ROM library.
`timescale 1ns/1ns
module haptic_loop_control_frontend
    import haptic_loop_pkg::*;
#(
    parameter int unsigned CAL_CYC_0 = CAL_MS_0 * CLK_KHZ,
    parameter int unsigned CAL_CYC_1 = CAL_MS_1 * CLK_KHZ,
    parameter int unsigned CAL_CYC_2 = CAL_MS_2 * CLK_KHZ,
    parameter int unsigned CAL_CYC_3 = CAL_MS_3 * CLK_KHZ,
    parameter int unsigned DIAG_CYC = DIAG_MS * CLK_KHZ
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic input_trigger_pin,
    input wire logic [7:0] backemf_level,
    input wire logic backemf_positive,
    input wire logic [7:0] load_impedance,
    output logic [7:0] drive_level,
    output logic drive_polarity,
    output logic drive_en,
    output logic backemf_sample,
    output logic [2:0] rom_library,
    output logic [1:0] backemf_amp_gain
);
    // Bus state
    logic rd_pend_q, wr_pend_q, hready_q, map_ok_q;
    logic [5:0] addr_q;
    logic [31:0] hrdata_q;
    logic [7:0] reg_rd;
    logic wr_en;
    logic [7:0] wdat;
    // Registers
    logic [7:0] mode_q, rated_q, od_q, comp_q, norm_q, fb_q, ctrl1_q, ctrl2_q, ctrl3_q;
    logic [7:0] period_q;
    logic [2:0] library_q;
    logic fault_q;
    // Sequencer
    seq_t seq_q;
    logic [26:0] seq_cnt_q, seq_limit;
    logic [7:0] peak_q;
    logic seq_done, go_start, go_abort;
    // Pin input
    logic [2:0] pin_sync_q;
    logic pin_q, pin_prev_q, pin_rise;
    logic [7:0] win_q, duty_q;
    logic [8:0] acc_q;
    logic [5:0] edge_cnt_q;
    logic ol_phase_q;
    // Loop
    logic [7:0] samp_cnt_q;
    logic sample_now;
    logic [2:0] boost_cnt_q;
    logic phase_prev_q;
    logic [15:0] half_cnt_q;
    logic signed [9:0] acc_drive_q;
    logic running, pwm_mode, is_lra, closed_loop, braking;
    logic [11:0] target, est;
    logic signed [12:0] err;
    logic [9:0] gain;
    logic signed [23:0] step_prod;
    logic signed [13:0] sum;
    logic signed [9:0] drive_next;
    logic [7:0] ol_level;
    logic [7:0] drive_level_q;
    logic drive_pol_q, drive_en_q, sample_q;

    assign hreadyout = hready_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign drive_level = drive_level_q;
    assign drive_polarity = drive_pol_q;
    assign drive_en = drive_en_q;
    assign backemf_sample = sample_q;
    assign rom_library = library_q;
    assign backemf_amp_gain = fb_q[FB_AMP_LSB +: 2];

    // AHB-Lite slave; reads wait one cycle so a write just before is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            hready_q <= 1'b1;
            map_ok_q <= 1'b0;
            addr_q <= 6'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            if (rd_pend_q) begin
                hrdata_q <= {24'h00_0000, reg_rd};
                hready_q <= 1'b1;
            end
            if (hsel && htrans[1] && hready) begin
                wr_pend_q <= hwrite;
                rd_pend_q <= !hwrite;
                hready_q <= hwrite;
                addr_q <= haddr[7:2];
                map_ok_q <= (haddr[31:8] == 24'h00_0000) && (hsize == 3'b010);
            end else begin
                wr_pend_q <= 1'b0;
                rd_pend_q <= 1'b0;
            end
        end
    end

    assign wr_en = wr_pend_q && map_ok_q;
    assign wdat = hwdata[7:0];

    always_comb begin
        reg_rd = 8'h00;
        if (map_ok_q) begin
            case (addr_q)
                IDX_STATUS: begin
                    reg_rd[STATUS_FAULT] = fault_q;
                    reg_rd[STATUS_BUSY] = (seq_q != SEQ_IDLE);
                end
                IDX_MODE: reg_rd = mode_q;
                IDX_LIBRARY: reg_rd = {5'h00, library_q};
                IDX_GO: reg_rd = {7'h00, (seq_q != SEQ_IDLE)};
                IDX_RATED: reg_rd = rated_q;
                IDX_OD_LIMIT: reg_rd = od_q;
                IDX_COMP: reg_rd = comp_q;
                IDX_BEMF_NORM: reg_rd = norm_q;
                IDX_FEEDBACK: reg_rd = fb_q;
                IDX_CTRL1: reg_rd = ctrl1_q;
                IDX_CTRL2: reg_rd = ctrl2_q;
                IDX_CTRL3: reg_rd = ctrl3_q;
                IDX_PERIOD: reg_rd = period_q;
                default: reg_rd = 8'h00;
            endcase
        end
    end

    // Plain software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= RST_MODE;
            library_q <= RST_LIBRARY;
            rated_q <= RST_RATED;
            od_q <= RST_OD_LIMIT;
            ctrl1_q <= RST_CTRL1;
            ctrl2_q <= RST_CTRL2;
            ctrl3_q <= RST_CTRL3;
        end else if (wr_en) begin
            case (addr_q)
                IDX_MODE: mode_q <= wdat;
                IDX_LIBRARY: library_q <= wdat[2:0];
                IDX_RATED: rated_q <= wdat;
                IDX_OD_LIMIT: od_q <= wdat;
                IDX_CTRL1: ctrl1_q <= wdat;
                IDX_CTRL2: ctrl2_q <= wdat;
                IDX_CTRL3: ctrl3_q <= wdat;
                default: ;
            endcase
        end
    end

    // Calibration results win over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_q <= RST_COMP;
            norm_q <= RST_BEMF_NORM;
            fb_q <= RST_FEEDBACK;
        end else if (seq_q == SEQ_CAL && seq_done && peak_q >= CAL_MIN_BEMF) begin
            comp_q <= load_impedance;
            norm_q <= rated_q;
            fb_q[FB_AMP_LSB +: 2] <= peak_q[7] ? 2'd0 : peak_q[6] ? 2'd1 :
                                     peak_q[5] ? 2'd2 : 2'd3;
        end else if (wr_en) begin
            if (addr_q == IDX_COMP) comp_q <= wdat;
            if (addr_q == IDX_BEMF_NORM) norm_q <= wdat;
            if (addr_q == IDX_FEEDBACK) fb_q <= wdat;
        end
    end

    // Calibration and diagnostic sequencer
    always_comb begin
        case (ctrl2_q[CTRL2_CALT_LSB +: 2])
            2'd0: seq_limit = 27'(CAL_CYC_0);
            2'd1: seq_limit = 27'(CAL_CYC_1);
            2'd2: seq_limit = 27'(CAL_CYC_2);
            default: seq_limit = 27'(CAL_CYC_3);
        endcase
        if (seq_q == SEQ_DIAG) seq_limit = 27'(DIAG_CYC);
    end

    assign seq_done = (seq_q != SEQ_IDLE) && (seq_cnt_q >= seq_limit - 27'd1);
    assign go_start = wr_en && addr_q == IDX_GO && wdat[0] && !mode_q[MODE_STANDBY];
    assign go_abort = wr_en && addr_q == IDX_GO && !wdat[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_q <= SEQ_IDLE;
            seq_cnt_q <= 27'd0;
            peak_q <= 8'h00;
        end else begin
            case (seq_q)
                SEQ_IDLE: begin
                    seq_cnt_q <= 27'd0;
                    peak_q <= 8'h00;
                    if (go_start && mode_q[2:0] == MODE_AUTOCAL) seq_q <= SEQ_CAL;
                    if (go_start && mode_q[2:0] == MODE_DIAG) seq_q <= SEQ_DIAG;
                end
                SEQ_CAL, SEQ_DIAG: begin
                    seq_cnt_q <= seq_cnt_q + 27'd1;
                    // Peak only over the second half, once the actuator has settled
                    if (seq_cnt_q >= (seq_limit >> 1) && backemf_level > peak_q)
                        peak_q <= backemf_level;
                    if (seq_done || go_abort || mode_q[MODE_STANDBY]) seq_q <= SEQ_IDLE;
                end
                default: seq_q <= SEQ_IDLE;
            endcase
        end
    end

    // Fault flag moves only when a run completes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_q <= 1'b0;
        end else if (seq_done && !go_abort) begin
            if (seq_q == SEQ_CAL)
                fault_q <= peak_q < CAL_MIN_BEMF;
            else
                fault_q <= load_impedance >= OPEN_LIMIT || load_impedance <= SHORT_LIMIT;
        end
    end

    // Pin synchroniser: a change counts once the second and third stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sync_q <= 3'b000;
            pin_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], input_trigger_pin};
            if (pin_sync_q[1] == pin_sync_q[2]) pin_q <= pin_sync_q[2];
            pin_prev_q <= pin_q;
        end
    end

    assign pin_rise = pin_q && !pin_prev_q;

    // Duty measured over a fixed 256-cycle window; slow PWM reads as ripple
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_q <= 8'h00;
            acc_q <= 9'h000;
            duty_q <= 8'h00;
        end else begin
            win_q <= win_q + 8'h01;
            if (win_q == 8'hFF) begin
                duty_q <= acc_q[8] ? 8'hFF : acc_q[7:0];
                acc_q <= {8'h00, pin_q};
            end else begin
                acc_q <= acc_q + {8'h00, pin_q};
            end
        end
    end

    // Open-loop commutation: half an output period every 64 input edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_cnt_q <= 6'h00;
            ol_phase_q <= 1'b0;
        end else if (pin_rise) begin
            edge_cnt_q <= edge_cnt_q + 6'h01;
            if (edge_cnt_q == 6'(PWM_HALF_DIV - 7'd1)) ol_phase_q <= !ol_phase_q;
        end
    end

    assign running = !mode_q[MODE_STANDBY] &&
                     (mode_q[2:0] == MODE_PWM || seq_q != SEQ_IDLE);
    assign pwm_mode = mode_q[2:0] == MODE_PWM;
    assign is_lra = fb_q[FB_ACT_LRA];
    assign closed_loop = seq_q == SEQ_CAL || (pwm_mode && seq_q == SEQ_IDLE &&
                         !(is_lra ? ctrl3_q[CTRL3_LRA_OL] : ctrl3_q[CTRL3_ERM_OL]));

    // Back-EMF sample strobe, one or two per drive period
    assign sample_now = samp_cnt_q == 8'h00 ||
                        (ctrl3_q[CTRL3_DOUBLE] && samp_cnt_q == SAMPLE_HALF);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_cnt_q <= 8'h00;
            boost_cnt_q <= 3'd0;
        end else begin
            samp_cnt_q <= samp_cnt_q + 8'h01;
            if (!running) boost_cnt_q <= 3'd0;
            else if (sample_now && boost_cnt_q < BOOST_SAMPLES) boost_cnt_q <= boost_cnt_q + 3'd1;
        end
    end

    // Loop arithmetic
    always_comb begin
        if (seq_q == SEQ_CAL) target = {4'h0, rated_q};
        else target = 12'((16'(duty_q) * 16'(rated_q) + 16'(rated_q)) >> 8);
        est = 12'(((22'(backemf_level) * 22'(norm_q)) <<
              (3'(fb_q[FB_AMP_LSB +: 2]) + 3'(ctrl2_q[CTRL2_SAMPLE_LSB +: 2]))) >> 10);
        err = $signed({1'b0, target}) - $signed({1'b0, est});
        braking = err < 0;
        gain = 10'd1 << fb_q[FB_LOOP_LSB +: 2];
        if (ctrl1_q[CTRL1_BOOST] && boost_cnt_q < BOOST_SAMPLES)
            gain = gain << 1;
        if (braking)
            gain = 10'(gain * BRAKE_MULT[fb_q[FB_BRAKE_LSB +: 3]]);
        if (braking && ctrl2_q[CTRL2_STAB] && est < BRAKE_NEAR)
            gain = gain >> 1;
        step_prod = $signed({{11{err[12]}}, err}) * $signed({14'h0000, gain});
        sum = 14'(step_prod >>> 4) + 14'(acc_drive_q);
        if (sum > $signed({6'h00, od_q})) drive_next = $signed({2'b00, od_q});
        else if (sum < -$signed({6'h00, od_q})) drive_next = -$signed({2'b00, od_q});
        else drive_next = 10'(sum);
        ol_level = 8'((16'(duty_q) * 16'(od_q) + 16'(od_q)) >> 8);
    end

    // Drive state and outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_drive_q <= 10'sd0;
            drive_level_q <= 8'h00;
            drive_pol_q <= 1'b0;
            drive_en_q <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            sample_q <= running && closed_loop && sample_now;
            drive_en_q <= running;
            if (!running || !closed_loop) acc_drive_q <= 10'sd0;
            else if (sample_now) acc_drive_q <= drive_next;
            if (!running) begin
                drive_level_q <= 8'h00;
                drive_pol_q <= 1'b0;
            end else if (seq_q == SEQ_DIAG) begin
                drive_level_q <= DIAG_LEVEL;
                drive_pol_q <= 1'b0;
            end else if (!closed_loop) begin
                drive_level_q <= ol_level;
                drive_pol_q <= is_lra && ol_phase_q;
            end else begin
                drive_level_q <= acc_drive_q[9] ? 8'(-acc_drive_q) : acc_drive_q[7:0];
                drive_pol_q <= (is_lra && backemf_positive) ^ acc_drive_q[9];
            end
        end
    end

    // Resonance period: half-cycle length between phase flips, held when not tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_prev_q <= 1'b0;
            half_cnt_q <= 16'h0000;
            period_q <= 8'h00;
        end else begin
            phase_prev_q <= backemf_positive;
            if (backemf_positive != phase_prev_q) begin
                half_cnt_q <= 16'h0000;
                if (running && closed_loop && is_lra && !braking)
                    period_q <= half_cnt_q[15] ? 8'hFF : half_cnt_q[14:7];
            end else if (half_cnt_q != 16'hFFFF) begin
                half_cnt_q <= half_cnt_q + 16'h0001;
            end
        end
    end
endmodule : haptic_loop_control_frontend

// ===== haptic_loop_assertions.sv
// Purpose: Port timing checks for the haptic loop front end.
// Assumes: One AHB master; hready is the slave's own hreadyout.
// Notes: Read data lands one edge after hreadyout falls.
`timescale 1ns/1ns
module haptic_loop_assertions
    import haptic_loop_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic drive_en,
    input wire logic backemf_sample,
    input wire logic [2:0] rom_library
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic taken = hsel & htrans[1] & hready;
    wire logic rd_taken = taken & !hwrite;
    wire logic lib_wr = taken & hwrite & (haddr == {24'h0, IDX_LIBRARY, 2'b00});
    wire logic mode_wr = taken & hwrite & (haddr == {24'h0, IDX_MODE, 2'b00});
    logic [7:0] gap_q;
    logic seen_q;
    // Gap saturates so a long idle spell cannot wrap into a false short gap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q <= 8'h00;
            seen_q <= 1'b0;
        end else if (backemf_sample) begin
            gap_q <= 8'h00;
            seen_q <= 1'b1;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
    a_read_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    a_ready_once: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
    a_rdata_hold: assert property (!$past(rd_taken, 2) |-> $stable(hrdata))
        else $error("hrdata moved without read");
    a_lib_follows: assert property ($past(lib_wr, 2) |-> rom_library == $past(hwdata[2:0]))
        else $error("library not loaded");
    a_sample_pulse: assert property (backemf_sample |=> !backemf_sample)
        else $error("sample pulse too wide");
    a_sample_gap: assert property (backemf_sample && seen_q |-> gap_q >= 8'h7F)
        else $error("samples too close");
    a_standby_stop: assert property (mode_wr ##1 hwdata[MODE_STANDBY] |-> ##[1:2] !drive_en)
        else $error("drive kept in standby");
    c_read: cover property (rd_taken);
    c_sample: cover property (backemf_sample);
    c_drive_stop: cover property ($fell(drive_en));
endmodule : haptic_loop_assertions
bind haptic_loop_control_frontend haptic_loop_assertions chk_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .drive_en,
    .backemf_sample, .rom_library);

// ===== actuator_model.sv
// Purpose: Behavioural vibration actuator on the drive outputs.
// Assumes: fault_kind 0 healthy, 1 open coil, 2 shorted coil.
// Notes: Back-EMF lags drive by one cycle, no inertia modelled.
`timescale 1ns/1ns
module actuator_model (
    input wire logic hclk,
    input wire logic [7:0] drive_level,
    input wire logic drive_polarity,
    input wire logic drive_en,
    input wire logic [1:0] fault_kind,
    output logic [7:0] backemf_level,
    output logic backemf_positive,
    output logic [7:0] load_impedance
);
    // A broken coil gives no back-EMF at all
    always_ff @(posedge hclk) begin
        backemf_level <= (drive_en && fault_kind == 2'h0) ? {1'b0, drive_level[7:1]} : 8'h00;
        backemf_positive <= drive_polarity;
    end
    assign load_impedance = (fault_kind == 2'h1) ? 8'hFF :
        (fault_kind == 2'h2) ? 8'h02 : 8'h20;
endmodule : actuator_model

// ===== testbench.sv
// Purpose: Register and drive scenarios for the haptic loop front end.
// Assumes: Short calibration and diagnostic counts set below.
// Notes: The 80-period duty windows are long enough for two 256-cycle updates.
`timescale 1ns/1ns
module testbench;
    import haptic_loop_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic input_trigger_pin = 1'b0;
    logic [1:0] fault_kind = 2'h0;
    wire logic hreadyout, hresp, drive_polarity, drive_en, backemf_sample, backemf_positive;
    wire logic [31:0] hrdata;
    wire logic [7:0] drive_level, backemf_level, load_impedance;
    wire logic [2:0] rom_library;
    wire logic [1:0] backemf_amp_gain;
    int bad_count = 0;
    int comparisons = 0;
    int toggles = 0;
    logic pol_q = 1'b0;
    logic [7:0] rd;
    localparam logic [5:0] RI [0:11] = '{IDX_STATUS, IDX_MODE, IDX_LIBRARY, IDX_RATED,
        IDX_OD_LIMIT, IDX_COMP, IDX_BEMF_NORM, IDX_FEEDBACK, IDX_CTRL1, IDX_CTRL2, IDX_CTRL3,
        IDX_PERIOD};
    localparam logic [7:0] RV [0:11] = '{8'h00, RST_MODE, {5'h00, RST_LIBRARY}, RST_RATED,
        RST_OD_LIMIT, RST_COMP, RST_BEMF_NORM, RST_FEEDBACK, RST_CTRL1, RST_CTRL2, RST_CTRL3, 8'h00};
    always #4 hclk = ~hclk;
    haptic_loop_control_frontend #(.CAL_CYC_0(200), .CAL_CYC_1(300), .CAL_CYC_2(400),
        .CAL_CYC_3(500), .DIAG_CYC(100)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .input_trigger_pin,
        .backemf_level, .backemf_positive, .load_impedance, .drive_level, .drive_polarity,
        .drive_en, .backemf_sample, .rom_library, .backemf_amp_gain);
    actuator_model model (.hclk, .drive_level, .drive_polarity, .drive_en, .fault_kind,
        .backemf_level, .backemf_positive, .load_impedance);
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            end_of_test;
        end
    endtask : wait_ready
    task xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready;
        rd = hrdata[7:0];
    endtask : xfer
    task rdchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(what, rd, exp);
    endtask : rdchk
    // Status is polled over the bus, never waited on blindly
    task run_to_idle(input logic exp_fault);
        int n;
        n = 0;
        do begin
            xfer(1'b0, IDX_STATUS, 8'h00);
            n++;
        end while (rd[STATUS_BUSY] !== 1'b0 && n < 400);
        if (n >= 400) begin
            bad_count++;
            end_of_test;
        end
        chk("fault flag", {7'h0, rd[STATUS_FAULT]}, {7'h0, exp_fault});
    endtask : run_to_idle
    task pwm(input int periods, input int high);
        repeat (periods) begin
            for (int k = 0; k < 8; k++) begin
                @(posedge hclk);
                input_trigger_pin <= (k < high);
                if (drive_polarity !== pol_q) toggles++;
                pol_q = drive_polarity;
            end
        end
    endtask : pwm
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 12; i++) rdchk("reset value", RI[i], RV[i]);
        xfer(1'b1, 6'h3F, 8'hA5);
        rdchk("unmapped", 6'h3F, 8'h00);
        for (int l = 0; l < 8; l++) begin
            xfer(1'b1, IDX_LIBRARY, l[7:0]);
            rdchk("library reg", IDX_LIBRARY, l[7:0]);
            chk("rom_library", {5'h0, rom_library}, l[7:0]);
        end
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, IDX_MODE, 8'h40 | m[7:0]);
            rdchk("mode", IDX_MODE, 8'h40 | m[7:0]);
        end
        xfer(1'b1, IDX_FEEDBACK, 8'h25);
        @(posedge hclk);
        chk("amp gain", {6'h0, backemf_amp_gain}, 8'h01);
        xfer(1'b1, IDX_CTRL3, 8'h04);
        for (int f = 0; f < 2; f++) begin
            fault_kind <= f[1:0];
            xfer(1'b1, IDX_CTRL2, (f == 0) ? 8'h10 : 8'h1C);
            xfer(1'b1, IDX_MODE, 8'h07);
            xfer(1'b1, IDX_GO, 8'h01);
            repeat (300) @(posedge hclk);
            xfer(1'b0, IDX_STATUS, 8'h00);
            chk("cal busy", {7'h0, rd[STATUS_BUSY]}, f[7:0]);
            run_to_idle(f[0]);
            if (f == 0) rdchk("comp", IDX_COMP, 8'h20);
            if (f == 0) rdchk("norm", IDX_BEMF_NORM, RST_RATED);
            if (f == 0) rdchk("amp cal", IDX_FEEDBACK, 8'h27);
        end
        fault_kind <= 2'h0;
        xfer(1'b1, IDX_MODE, 8'h06);
        xfer(1'b1, IDX_GO, 8'h01);
        xfer(1'b1, IDX_GO, 8'h00);
        run_to_idle(1'b1);
        for (int k = 0; k < 3; k++) begin
            fault_kind <= k[1:0];
            xfer(1'b1, IDX_GO, 8'h01);
            run_to_idle(k != 0);
        end
        fault_kind <= 2'h0;
        xfer(1'b1, IDX_FEEDBACK, 8'h24);
        xfer(1'b1, IDX_CTRL3, 8'h20);
        xfer(1'b1, IDX_MODE, 8'h03);
        pwm(80, 8);
        chk("erm full duty", drive_level, RST_OD_LIMIT);
        chk("drive on", {7'h0, drive_en}, 8'h01);
        pwm(80, 0);
        chk("erm zero duty", drive_level, 8'h00);
        xfer(1'b1, IDX_FEEDBACK, 8'hA4);
        xfer(1'b1, IDX_CTRL3, 8'h01);
        pwm(40, 4);
        toggles = 0;
        pwm(128, 4);
        chk("lra toggles", toggles[7:0], 8'h02);
        xfer(1'b1, IDX_MODE, 8'h43);
        repeat (2) @(posedge hclk);
        chk("standby drive", {7'h0, drive_en}, 8'h00);
        end_of_test;
    end
endmodule : testbench
